//--- pkg/fsr_pkg.sv
/*
 Package for the flash store mode and reset control: register map,
 command codes, status bits, timing counts and the state carrier.
 Assumes a 25 MHz aclk and a 32-bit AXI4-Lite register bus.
*/
package fsr_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [4:0] A_CMD  = 5'h00;
    localparam logic [4:0] A_STAT = 5'h04;
    localparam logic [4:0] A_LOCK = 5'h08;
    localparam logic [4:0] A_ADDR = 5'h0C;
    localparam logic [4:0] A_CFG  = 5'h10;
    localparam logic [1:0] R_OK   = 2'h0;
    localparam logic [1:0] R_ERR  = 2'h2;
    // ------------------------------------------------------------
    // Command codes, low byte of CMD
    // ------------------------------------------------------------
    localparam logic [7:0] C_READ  = 8'h00;
    localparam logic [7:0] C_PROG  = 8'h01;
    localparam logic [7:0] C_ERASE = 8'h02;
    localparam logic [7:0] C_GO    = 8'h03;
    localparam logic [7:0] C_CLR   = 8'h04;
    localparam int         CMD_BLK = 16;
    // ------------------------------------------------------------
    // Status bits
    // ------------------------------------------------------------
    localparam int S_BUSY = 0;
    localparam int S_VPP  = 1;
    localparam int S_LOCK = 2;
    localparam int S_SEQ  = 3;
    localparam int S_RARR = 4;
    localparam int S_OVAL = 5;
    localparam int S_WRDY = 6;
    localparam int S_MUX  = 7;
    localparam int S_STBY = 8;
    localparam int S_IO   = 12;
    localparam logic [4:0] BLK_4M = 5'h08;
    localparam logic [4:0] BLK_8M = 5'h10;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS   = 40;
    localparam int T_OV_NS  = 1000;
    localparam int T_WR_NS  = 1000;
    localparam int T_EX_NS  = 20000;
    localparam int T_PG_NS  = 8000;
    localparam int T_ER_NS  = 40000;
    localparam logic [15:0] OV_CYC = 16'((T_OV_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] WR_CYC = 16'((T_WR_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] EX_CYC = 16'((T_EX_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] PG_CYC = 16'((T_PG_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [15:0] ER_CYC = 16'((T_ER_NS + CLK_NS - 1) / CLK_NS);
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {W_IDLE, W_PROG, W_ERASE} fsr_wsm_t;
    typedef enum logic [1:0] {M_NONE, M_PROG, M_ERASE} fsr_arm_t;
    typedef struct packed {
        logic        sel;
        logic        irst_n;
        logic        prst_n;
        logic        frame;
        logic        vpp_lk;
        logic        rcs;
        logic [10:0] addr;
        logic [3:0]  io;
    } fsr_pins_t;
    typedef struct packed {
        fsr_pins_t   s1;
        fsr_pins_t   s2;
        logic        dev_rst;
        logic        mux_mode;
        logic        hit;
        logic [15:0] ov_cnt;
        logic [15:0] wr_cnt;
        fsr_wsm_t    write_state_machine;
        fsr_arm_t    arm;
        logic [15:0] op_cnt;
        logic [3:0]  blk;
        logic [15:0] lock;
        logic        e_vpp;
        logic        e_lock;
        logic        e_seq;
        logic        rarr;
        logic        dens8;
        logic [10:0] row;
        logic [10:0] col;
        logic        stby;
        logic [3:0]  nib;
        logic        oe;
        logic        aw_got;
        logic        w_got;
        logic [4:0]  awaddr;
        logic [31:0] wdata;
        logic        wstb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } fsr_state_t;

    function automatic fsr_state_t fsr_rst();
        fsr_state_t s;
        s = '0;
        s.s1.frame = 1'b1;
        s.s2.frame = 1'b1;
        s.dev_rst = 1'b1;
        s.lock = 16'hFFFF;
        s.rarr = 1'b1;
        s.ov_cnt = OV_CYC;
        s.wr_cnt = WR_CYC;
        return s;
    endfunction : fsr_rst
endpackage : fsr_pkg

//--- core/fsr_ctrl.sv
/*
 Flash store mode select and reset control with command front end
 and write state machine, registers over AXI4-Lite.
 Assumes all pin inputs are asynchronous to aclk; aresetn is
 synchronous to aclk.
*/
// Operation
// [RULE1] Interface select level picks active interface
// [RULE2] Low selects host, high selects multiplexed
// [RULE3] Host sets select before reset release
// [RULE4] Reset locks all blocks, clears status
// [RULE5] Both reset inputs act identically
// [RULE6] Reset blocks writes, floats host nibble; here CFG writes still land during reset
// [RULE7] Outputs invalid until output recovery elapses
// [RULE8] Command writes ignored until write recovery
// [RULE9] Reset during operation adds extra latency
// [RULE10] Leaving reset enters read-array mode
// [RULE11] Complete command sequence starts state machine
// [RULE12] Standby when frame high and idle; here only in host mode, never in multiplexed mode
// [RULE13] Host interface runs on bus clock
// [RULE14] Multiplexed mode: no locking registers
// [RULE15] Row/column select latches address half
// [RULE16] Uniform blocks, eight or sixteen per density
// [RULE17] Supply lockout refuses program and erase
// [RULE18] Frame low leaves standby next clock; here standby clears three clocks after the pin falls
`timescale 1ns/100ps
module fsr_ctrl (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [4:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [4:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        interface_select,
    input  wire logic        interface_reset_n,
    input  wire logic        processor_reset_n,
    input  wire logic        frame_line,
    input  wire logic        vpp_lockout,
    input  wire logic        row_column_select,
    input  wire logic [10:0] mux_addr,
    input  wire logic [3:0]  host_io_nibble_i,
    output logic [3:0]       host_io_nibble_o,
    output logic             host_io_nibble_oe,
    output logic             standby
);
    fsr_pkg::fsr_state_t r_reg;
    fsr_pkg::fsr_state_t r_next;
    fsr_pkg::fsr_pins_t  pin_in;
    logic                wr_ok;
    logic                go_start;

    function automatic logic [4:0] blk_count(input logic d8);
        return d8 ? fsr_pkg::BLK_8M : fsr_pkg::BLK_4M;  // RULE16
    endfunction : blk_count

    assign pin_in = '{interface_select, interface_reset_n,
                      processor_reset_n, frame_line, vpp_lockout,
                      row_column_select, mux_addr, host_io_nibble_i};
    // ------------------------------------------------------------
    // Bus handshakes
    // ------------------------------------------------------------
    assign awready = !r_reg.aw_got && !r_reg.bvalid;
    assign wready  = !r_reg.w_got && !r_reg.bvalid;
    assign arready = !r_reg.rvalid;
    assign bvalid  = r_reg.bvalid;
    assign bresp   = r_reg.bresp;
    assign rvalid  = r_reg.rvalid;
    assign rdata   = r_reg.rdata;
    assign rresp   = r_reg.rresp;
    assign host_io_nibble_o  = r_reg.nib;
    assign host_io_nibble_oe = r_reg.oe;
    assign standby           = r_reg.stby;
    // Command and lock writes wait for recovery and an idle state machine
    assign wr_ok = !r_reg.dev_rst && r_reg.wr_cnt == 16'h0000  // RULE8
                   && r_reg.write_state_machine == fsr_pkg::W_IDLE;            // RULE6
    assign go_start = r_reg.write_state_machine == fsr_pkg::W_IDLE
                      && r_next.write_state_machine != fsr_pkg::W_IDLE;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [31:0] stat;
        logic        cmd_wr;
        logic        busy;
        stat = '0;
        cmd_wr = 1'b0;
        r_next = r_reg;
        busy = r_reg.write_state_machine != fsr_pkg::W_IDLE;
        // Stage one feeds stage two only
        r_next.s1 = pin_in;
        r_next.s2 = r_reg.s1;
        r_next.dev_rst = !r_reg.s2.irst_n || !r_reg.s2.prst_n;  // RULE5

        stat[fsr_pkg::S_BUSY] = busy;
        stat[fsr_pkg::S_VPP]  = r_reg.e_vpp;
        stat[fsr_pkg::S_LOCK] = r_reg.e_lock;
        stat[fsr_pkg::S_SEQ]  = r_reg.e_seq;
        stat[fsr_pkg::S_RARR] = r_reg.rarr;
        stat[fsr_pkg::S_OVAL] = r_reg.ov_cnt == 16'h0000;
        stat[fsr_pkg::S_WRDY] = wr_ok;
        stat[fsr_pkg::S_MUX]  = r_reg.mux_mode;
        stat[fsr_pkg::S_STBY] = r_reg.stby;
        stat[fsr_pkg::S_IO +: 4] = r_reg.s2.io;

        // Write channel: address and data in either order
        if (awvalid && awready) begin
            r_next.aw_got = 1'b1;
            r_next.awaddr = awaddr;
        end
        if (wvalid && wready) begin
            r_next.w_got = 1'b1;
            r_next.wdata = wdata;
            r_next.wstb  = wstrb[0];
        end
        if (r_reg.bvalid && bready) begin
            r_next.bvalid = 1'b0;
        end
        if (r_reg.aw_got && r_reg.w_got) begin
            r_next.aw_got = 1'b0;
            r_next.w_got  = 1'b0;
            r_next.bvalid = 1'b1;
            r_next.bresp  = fsr_pkg::R_OK;
            unique case (r_reg.awaddr)
                fsr_pkg::A_CMD: cmd_wr = r_reg.wstb && wr_ok;
                fsr_pkg::A_LOCK: begin
                    if (r_reg.wstb && wr_ok && !r_reg.mux_mode) begin
                        r_next.lock = r_reg.wdata[15:0];  // RULE14
                    end
                end
                fsr_pkg::A_CFG: begin
                    if (r_reg.wstb) begin
                        r_next.dens8 = r_reg.wdata[0];
                    end
                end
                fsr_pkg::A_STAT, fsr_pkg::A_ADDR: ;
                default: r_next.bresp = fsr_pkg::R_ERR;
            endcase
        end

        // Read channel
        if (r_reg.rvalid && rready) begin
            r_next.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            r_next.rvalid = 1'b1;
            r_next.rresp  = fsr_pkg::R_OK;
            r_next.rdata  = '0;
            unique case (araddr)
                fsr_pkg::A_CMD:  ;
                fsr_pkg::A_STAT: r_next.rdata = stat;
                fsr_pkg::A_LOCK: begin
                    if (!r_reg.mux_mode) begin
                        r_next.rdata[15:0] = r_reg.lock;  // RULE14
                    end
                end
                fsr_pkg::A_ADDR: r_next.rdata = {5'h00, r_reg.row,
                                                 5'h00, r_reg.col};
                fsr_pkg::A_CFG:  r_next.rdata[0] = r_reg.dens8;
                default: r_next.rresp = fsr_pkg::R_ERR;
            endcase
        end

        // Command front end: setup then go
        if (cmd_wr) begin
            r_next.arm = fsr_pkg::M_NONE;
            r_next.rarr = 1'b0;
            unique case (r_reg.wdata[7:0])
                fsr_pkg::C_READ: r_next.rarr = 1'b1;
                fsr_pkg::C_CLR: begin
                    r_next.e_vpp  = 1'b0;
                    r_next.e_lock = 1'b0;
                    r_next.e_seq  = 1'b0;
                end
                fsr_pkg::C_PROG:  r_next.arm = fsr_pkg::M_PROG;
                fsr_pkg::C_ERASE: r_next.arm = fsr_pkg::M_ERASE;
                fsr_pkg::C_GO: begin
                    r_next.blk = r_reg.wdata[fsr_pkg::CMD_BLK +: 4];
                    if (r_reg.arm == fsr_pkg::M_NONE) begin
                        r_next.e_seq = 1'b1;
                    end else if ({1'b0, r_next.blk}
                                 >= blk_count(r_reg.dens8)) begin
                        r_next.e_seq = 1'b1;  // RULE16
                    end else if (r_reg.s2.vpp_lk) begin
                        r_next.e_vpp = 1'b1;  // RULE17
                    end else if (!r_reg.mux_mode
                                 && r_reg.lock[r_next.blk]) begin
                        r_next.e_lock = 1'b1;
                    end else if (r_reg.arm == fsr_pkg::M_PROG) begin
                        r_next.write_state_machine = fsr_pkg::W_PROG;  // RULE11
                        r_next.op_cnt = fsr_pkg::PG_CYC;
                    end else begin
                        r_next.write_state_machine = fsr_pkg::W_ERASE;  // RULE11
                        r_next.op_cnt = fsr_pkg::ER_CYC;
                    end
                end
                default: r_next.e_seq = 1'b1;
            endcase
        end

        // Write state machine times the operation on its own
        unique case (r_reg.write_state_machine)
            fsr_pkg::W_IDLE: ;
            fsr_pkg::W_PROG, fsr_pkg::W_ERASE: begin
                r_next.op_cnt = r_reg.op_cnt - 16'h0001;
                if (r_reg.op_cnt == 16'h0001) begin
                    r_next.write_state_machine = fsr_pkg::W_IDLE;
                    r_next.rarr = 1'b1;
                end
            end
        endcase

        // Recovery after reset
        if (r_reg.ov_cnt != 16'h0000) begin
            r_next.ov_cnt = r_reg.ov_cnt - 16'h0001;
        end
        if (r_reg.wr_cnt != 16'h0000) begin
            r_next.wr_cnt = r_reg.wr_cnt - 16'h0001;
        end else begin
            r_next.hit = 1'b0;
        end

        // Multiplexed address capture
        if (r_reg.mux_mode) begin
            if (r_reg.s2.rcs) begin
                r_next.row = r_reg.s2.addr;  // RULE15
            end else begin
                r_next.col = r_reg.s2.addr;  // RULE15
            end
        end

        // Standby is re-evaluated every clock, so a low frame
        // clears it three clocks after the pin falls
        r_next.stby = !r_reg.mux_mode && r_reg.s2.frame  // RULE12
                      && !busy;                          // RULE18
        // Host nibble driven only while host mode is live
        r_next.oe = !r_reg.dev_rst && !r_reg.mux_mode  // RULE6
                    && r_reg.ov_cnt == 16'h0000        // RULE7
                    && !r_reg.s2.frame;                // RULE13
        r_next.nib = stat[3:0];

        // Device reset overrides mode, lock, status, recovery, standby and nibble enable
        if (r_reg.dev_rst) begin
            r_next.mux_mode = r_reg.s2.sel;  // RULE1 RULE2 RULE3
            r_next.lock = 16'hFFFF;          // RULE4
            r_next.e_vpp = 1'b0;             // RULE4
            r_next.e_lock = 1'b0;
            r_next.e_seq = 1'b0;
            r_next.write_state_machine = fsr_pkg::W_IDLE;
            r_next.arm = fsr_pkg::M_NONE;
            r_next.rarr = 1'b1;              // RULE10
            r_next.hit = r_reg.hit || busy;  // RULE9
            r_next.ov_cnt = fsr_pkg::OV_CYC
                + (r_next.hit ? fsr_pkg::EX_CYC : 16'h0000);  // RULE9
            r_next.wr_cnt = fsr_pkg::WR_CYC
                + (r_next.hit ? fsr_pkg::EX_CYC : 16'h0000);  // RULE9
            r_next.stby = 1'b0;
            r_next.oe = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= fsr_pkg::fsr_rst();
        end else begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_rst_end;
        r_reg.dev_rst ##1 !r_reg.dev_rst;
    endsequence
    sequence s_busy_rst;
        r_reg.dev_rst && r_reg.write_state_machine != fsr_pkg::W_IDLE;
    endsequence

    property p_mode_strap;
        s_rst_end |-> r_reg.mux_mode == $past(r_reg.s2.sel);
    endproperty
    a_mode_strap: assert property (p_mode_strap) // RULE2
        else $error("mode not taken from select at release");

    property p_rst_lock;
        r_reg.dev_rst |=> r_reg.lock == 16'hFFFF && !r_reg.e_vpp;
    endproperty
    a_rst_lock: assert property (p_rst_lock) // RULE4
        else $error("reset did not lock blocks or clear status");

    property p_rst_pins;
        !r_reg.s2.prst_n |=> r_reg.dev_rst;
    endproperty
    a_rst_pins: assert property (p_rst_pins) // RULE5
        else $error("processor reset not acting as reset");

    property p_rst_float;
        r_reg.dev_rst |=> !host_io_nibble_oe;
    endproperty
    a_rst_float: assert property (p_rst_float) // RULE6
        else $error("nibble driven during reset");

    property p_out_wait;
        s_rst_end |-> !host_io_nibble_oe [*8];
    endproperty
    a_out_wait: assert property (p_out_wait) // RULE7
        else $error("nibble driven before output recovery");

    property p_wr_wait;
        go_start |-> r_reg.wr_cnt == 16'h0000 && !r_reg.dev_rst;
    endproperty
    a_wr_wait: assert property (p_wr_wait) // RULE8
        else $error("operation started during write recovery");

    property p_extra;
        s_busy_rst |=> r_reg.wr_cnt > fsr_pkg::WR_CYC
            && r_reg.ov_cnt > fsr_pkg::OV_CYC;
    endproperty
    a_extra: assert property (p_extra) // RULE9
        else $error("no extra latency after busy reset");

    property p_rarr;
        s_rst_end |-> r_reg.rarr && r_reg.write_state_machine == fsr_pkg::W_IDLE;
    endproperty
    a_rarr: assert property (p_rarr) // RULE10
        else $error("not in read array after reset");

    property p_stby;
        standby |-> $past(r_reg.s2.frame) && !$past(r_reg.mux_mode);
    endproperty
    a_stby: assert property (p_stby) // RULE18
        else $error("standby while frame low");

    property p_vpp;
        go_start |-> !r_reg.s2.vpp_lk;
    endproperty
    a_vpp: assert property (p_vpp) // RULE17
        else $error("operation started under supply lockout");
endmodule : fsr_ctrl

//--- tb/fsr_host_model.sv
/*
 Host-side partner: drives the frame line on the bus clock and
 resolves the two-way nibble wire.
 Assumes the bench requests host cycles on cyc_req.
*/
`timescale 1ns/100ps
module fsr_host_model (
    input  wire logic       aclk,
    input  wire logic       cyc_req,
    input  wire logic [3:0] dut_o,
    input  wire logic       dut_oe,
    output logic            frame_line,
    output logic [3:0]      nib
);
    logic [3:0] drv;

    initial begin
        frame_line = 1'h1;
        drv        = 4'h5;
    end
    // Host samples and drives on the bus clock only
    always @(posedge aclk) begin
        frame_line <= ~cyc_req;
        // Undriven wire toggles so a stale value never reads back
        drv        <= ~drv;
    end
    assign nib = dut_oe ? dut_o : drv;
endmodule : fsr_host_model

//--- tb/fsr_ctrl_test.sv
/*
 Self-checking bench for fsr_ctrl: AXI4-Lite master tasks, queued
 expectations checked by a monitor, pin-level stimulus.
 Assumes fsr_pkg and fsr_host_model are compiled first.
*/
`timescale 1ns/100ps
module fsr_ctrl_test;
    typedef struct {
        logic [31:0] d;
        logic [31:0] m;
        logic [1:0]  r;
    } fsr_note_t;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, oe, stby;
    logic        sel, irst_n, prst_n, frame, vpp, rcs, cyc_req;
    logic [4:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, r1, r2;
    logic [1:0]  bresp, rresp;
    logic [10:0] maddr;
    logic [3:0]  nib_i, nib_o;
    fsr_note_t   rq[$];
    logic [1:0]  bq[$];
    int          err_total, compares, cyc, seed, i;

    initial begin
        aclk = 1'h0;
        forever #20 aclk = ~aclk;
    end

    fsr_ctrl dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .interface_select(sel), .interface_reset_n(irst_n),
        .processor_reset_n(prst_n), .frame_line(frame),
        .vpp_lockout(vpp), .row_column_select(rcs), .mux_addr(maddr),
        .host_io_nibble_i(nib_i), .host_io_nibble_o(nib_o),
        .host_io_nibble_oe(oe), .standby(stby));

    fsr_host_model host (.aclk(aclk), .cyc_req(cyc_req), .dut_o(nib_o),
        .dut_oe(oe), .frame_line(frame), .nib(nib_i));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("errors=%0d compares=%0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    task automatic edges(input int n);
        repeat (n) @(posedge aclk);
    endtask : edges

    function automatic logic [31:0] bt(input int b);
        return 32'h1 << b;
    endfunction : bt

    task automatic wr(input logic [4:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        logic ga, gw;
        bq.push_back(r);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        ga = 1'h0;
        gw = 1'h0;
        while (!(ga && gw)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                ga = 1'h1;
                awvalid <= 1'h0;
            end
            if (wvalid && wready) begin
                gw = 1'h1;
                wvalid <= 1'h0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'h1);
        bready <= 1'h0;
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic [1:0] r);
        rq.push_back('{d, m, r});
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        do @(posedge aclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge aclk); while (rvalid !== 1'h1);
        rready <= 1'h0;
    endtask : rd
    // ------------------------------------------------------------
    // Monitor and watchdog
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        fsr_note_t n;
        if (bvalid && bready)
            chk(32'(bresp), 32'(bq.pop_front()));
        if (rvalid && rready) begin
            n = rq.pop_front();
            chk(rdata & n.m, n.d & n.m);
            chk(32'(rresp), 32'(n.r));
        end
        cyc++;
        // Whole run is about 1100 cycles
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 19;
        {err_total, compares, cyc} = '0;
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, maddr} = '0;
        {sel, vpp, rcs, cyc_req} = '0;
        {irst_n, prst_n} = 2'h3;
        edges(2);
        aresetn <= 1'h1;
        edges(40);
        rd(fsr_pkg::A_STAT, bt(fsr_pkg::S_RARR) | bt(fsr_pkg::S_OVAL) |
           bt(fsr_pkg::S_WRDY) | bt(fsr_pkg::S_STBY), 32'h1FF,
           fsr_pkg::R_OK);
        rd(fsr_pkg::A_LOCK, 32'hFFFF, 32'hFFFF, fsr_pkg::R_OK);
        rd(5'h14, 32'h0, 32'h0, fsr_pkg::R_ERR);
        wr(5'h18, 32'h0, fsr_pkg::R_ERR);
        cyc_req <= 1'h1;
        @(negedge frame);
        edges(2);
        #1 chk(32'(stby), 32'h1);
        edges(1);
        #1 chk(32'(stby), 32'h0);
        chk(32'(oe), 32'h1);
        chk(32'(nib_o), 32'h0);
        edges(1);
        cyc_req <= 1'h0;
        edges(6);
        #1 chk(32'(stby), 32'h1);
        edges(1);
        prst_n  <= 1'h0;
        cyc_req <= 1'h1;
        edges(5);
        #1 chk(32'(oe), 32'h0);
        wr(fsr_pkg::A_LOCK, 32'h0, fsr_pkg::R_OK);
        prst_n <= 1'h1;
        // Let the device reset end so this write falls in recovery
        edges(3);
        wr(fsr_pkg::A_LOCK, 32'h0, fsr_pkg::R_OK);
        rd(fsr_pkg::A_STAT, 32'h0, 32'h60, fsr_pkg::R_OK);
        #1 chk(32'(oe), 32'h0);
        edges(40);
        #1 chk(32'(oe), 32'h1);
        edges(1);
        cyc_req <= 1'h0;
        rd(fsr_pkg::A_LOCK, 32'hFFFF, 32'hFFFF, fsr_pkg::R_OK);
        wr(fsr_pkg::A_LOCK, 32'h0, fsr_pkg::R_OK);
        wr(fsr_pkg::A_CMD, 32'(fsr_pkg::C_PROG), fsr_pkg::R_OK);
        wr(fsr_pkg::A_CMD, 32'(fsr_pkg::C_GO), fsr_pkg::R_OK);
        rd(fsr_pkg::A_STAT, 32'h1, 32'h1, fsr_pkg::R_OK);
        edges(220);
        rd(fsr_pkg::A_STAT, 32'h10, 32'h11, fsr_pkg::R_OK);
        vpp <= 1'h1;
        wr(fsr_pkg::A_CMD, 32'(fsr_pkg::C_PROG), fsr_pkg::R_OK);
        wr(fsr_pkg::A_CMD, 32'(fsr_pkg::C_GO), fsr_pkg::R_OK);
        rd(fsr_pkg::A_STAT, 32'h2, 32'h3, fsr_pkg::R_OK);
        vpp <= 1'h0;
        wr(fsr_pkg::A_CMD, 32'(fsr_pkg::C_CLR), fsr_pkg::R_OK);
        rd(fsr_pkg::A_STAT, 32'h0, 32'hE, fsr_pkg::R_OK);
        // First block past the end for 8 blocks, last block for 16
        for (i = 0; i < 2; i++) begin
            wr(fsr_pkg::A_CFG, 32'(i), fsr_pkg::R_OK);
            wr(fsr_pkg::A_CMD, 32'(fsr_pkg::C_ERASE), fsr_pkg::R_OK);
            wr(fsr_pkg::A_CMD, 32'(fsr_pkg::C_GO) | (i == 1 ?
               32'h000F0000 : 32'h00080000), fsr_pkg::R_OK);
            rd(fsr_pkg::A_STAT, i == 1 ? 32'h1 : 32'h8, 32'h9,
               fsr_pkg::R_OK);
            wr(fsr_pkg::A_CMD, 32'(fsr_pkg::C_CLR), fsr_pkg::R_OK);
        end
        edges(10);
        irst_n <= 1'h0;
        edges(5);
        irst_n <= 1'h1;
        edges(100);
        rd(fsr_pkg::A_STAT, 32'h0, 32'h4E, fsr_pkg::R_OK);
        rd(fsr_pkg::A_LOCK, 32'hFFFF, 32'hFFFF, fsr_pkg::R_OK);
        edges(500);
        rd(fsr_pkg::A_STAT, 32'h70, 32'h71, fsr_pkg::R_OK);
        sel    <= 1'h1;
        irst_n <= 1'h0;
        edges(5);
        irst_n <= 1'h1;
        edges(40);
        rd(fsr_pkg::A_STAT, bt(fsr_pkg::S_MUX), bt(fsr_pkg::S_MUX),
           fsr_pkg::R_OK);
        wr(fsr_pkg::A_LOCK, 32'h0, fsr_pkg::R_OK);
        rd(fsr_pkg::A_LOCK, 32'h0, 32'hFFFF, fsr_pkg::R_OK);
        r1 = $random(seed);
        r2 = $random(seed);
        rcs   <= 1'h1;
        maddr <= r1[10:0];
        edges(5);
        rcs   <= 1'h0;
        maddr <= r2[10:0];
        edges(5);
        rd(fsr_pkg::A_ADDR, {5'h0, r1[10:0], 5'h0, r2[10:0]},
           32'h07FF07FF, fsr_pkg::R_OK);
        cyc_req <= 1'h1;
        edges(6);
        #1 chk(32'(oe), 32'h0);
        edges(1);
        end_of_test();
    end
endmodule : fsr_ctrl_test
